// *** hw/lhs_lin_header_sync_engine.sv ***
// Notes on behaviour
// - mode field 0xA selects master node, 0xB selects slave node
// - master uses baud generator; slave copies each baud write into lin baud
// - identifier write in master mode starts header and drops transmitter ready
// - break, synch and identifier fields go out back to back
// - break is 13 dominant bits then 1 recessive bit
// - synch field is 0x55, identifier field is the protected identifier, or the written byte with parity disabled
// - transmitter ready rises when identifier enters the shift register
// - slave detects break after 11 bit times low at current rate
// - slave ignores all characters until a break is seen
// - synch not 0x55 keeps rate and flags bad synch character
// - received identifier sets its flag and loads identifier field
// - header not complete within maximum duration flags header timeout
// - status reset clears identifier, break and timeout flags
// - resync only in slave mode, from synch falling edges
// - 19-bit counter on sampling clock measures eight synch bit times
// - counter upper 16 bits give divider, lower 3 give fraction
// - computed rate written to lin baud unless resync disabled
// - rate off by more than 15 percent keeps rate, flags tolerance error
// - status reset clears tolerance and bad synch flags
// - identifier bits 5:0 plus two parity bits, parity optional
module lhs_lin_header_sync_engine (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [lhs_pkg::AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic lin_rxd,
	output logic lin_txd
);
	import lhs_pkg::*;

	function automatic logic [31:0] be_merge(input logic [31:0] old_w, input logic [31:0] new_w,
			input logic [3:0] be);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] lin_pid(input logic [5:0] id);
		return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
	endfunction

	// baud word as a rate in eighths of the divider
	function automatic logic [BR_W-1:0] to_eighths(input logic [BR_W-1:0] br);
		return {br[FP_LSB-1:0], br[BR_W-1:FP_LSB]};
	endfunction

	logic [3:0] mode_q;
	logic par_dis_q;
	logic sync_dis_q;
	logic [BR_W-1:0] brg_q;
	logic [BR_W-1:0] lbr_q;
	logic [7:0] id_q;
	logic transmitter_ready_flag_q;
	logic idrx_q;
	logic brk_q;
	logic hte_q;
	logic ste_q;
	logic bad_synch_char_error_q;
	logic pare_q;

	lhs_tx_e tx_st_q;
	logic [19:0] tx_cyc_q;
	logic [3:0] tx_bits_q;
	logic [8:0] tx_sh_q;

	lhs_rx_e rx_st_q;
	logic rx_prev_q;
	logic [23:0] low_cnt_q;
	logic [19:0] rx_cyc_q;
	logic [3:0] rx_bits_q;
	logic [7:0] rx_sh_q;
	logic hdr_on_q;
	logic [19:0] hdr_cyc_q;
	logic [5:0] hdr_bits_q;
	logic [3:0] samp_div_q;
	logic [BR_W-1:0] meas_q;
	logic meas_on_q;
	logic [2:0] edges_q;

	// bus decode
	wire wr_go = avs_write && !avs_waitrequest;
	wire sel_ctrl = avs_address == ADDR_CTRL;
	wire sel_mode = avs_address == ADDR_MODE;
	wire sel_brg = avs_address == ADDR_BRG;
	wire sel_lbr = avs_address == ADDR_LBR;
	wire sel_id = avs_address == ADDR_ID;
	wire sel_stat = avs_address == ADDR_STAT;
	wire wr_ctrl = wr_go && sel_ctrl && avs_byteenable[0];
	wire wr_mode = wr_go && sel_mode;
	wire wr_brg = wr_go && sel_brg;
	wire wr_id = wr_go && sel_id && avs_byteenable[0];
	wire sts_clr = wr_ctrl && avs_writedata[CTRL_STATUS_RESET_BIT];
	wire rst_rx = wr_ctrl && avs_writedata[CTRL_RSTRX];
	wire rst_tx = wr_ctrl && avs_writedata[CTRL_RSTTX];

	wire [31:0] mode_word = {26'h0, sync_dis_q, par_dis_q, mode_q};
	wire [31:0] mode_new = be_merge(mode_word, avs_writedata, avs_byteenable);
	wire [31:0] brg_new = be_merge({13'h0, brg_q}, avs_writedata, avs_byteenable);
	logic [31:0] stat_word;
	wire [31:0] rd_word = sel_ctrl ? 32'h0 :
		sel_mode ? mode_word :
		sel_brg ? {13'h0, brg_q} :
		sel_lbr ? {13'h0, lbr_q} :
		sel_id ? {24'h0, id_q} :
		sel_stat ? stat_word : 32'h0;

	always_comb begin
		stat_word = 32'h0;
		stat_word[STAT_TRANSMITTER_READY_FLAG] = transmitter_ready_flag_q;
		stat_word[STAT_IDRX] = idrx_q;
		stat_word[STAT_BRK] = brk_q;
		stat_word[STAT_HTE] = hte_q;
		stat_word[STAT_STE] = ste_q;
		stat_word[STAT_BAD_SYNCH_CHAR_ERROR] = bad_synch_char_error_q;
		stat_word[STAT_PARE] = pare_q;
	end

	// rate selection and bit timing: one bit is 16 ref clocks per divider unit
	wire is_master = mode_q == MODE_MASTER;
	wire is_slave = mode_q == MODE_SLAVE;
	wire [BR_W-1:0] cur_br = is_slave ? lbr_q : brg_q;
	wire [19:0] bit_len = {to_eighths(cur_br), 1'b0};
	wire [19:0] bit_last = bit_len - 20'h1;
	wire [23:0] brk_thr = 24'(bit_len) * 24'(BRK_DET_BITS);

	// transmitter
	wire tx_tick = tx_cyc_q == bit_last;
	wire hdr_go = wr_id && is_master && transmitter_ready_flag_q;
	wire [7:0] tx_id_char = par_dis_q ? id_q : lin_pid(id_q[5:0]);
	wire tx_char_end = tx_tick && tx_bits_q == CHAR_LAST;

	// receiver
	wire rx_fall = rx_prev_q && !lin_rxd;
	wire brk_hit = !lin_rxd && low_cnt_q == brk_thr - 24'h1;
	wire rx_samp = rx_cyc_q == bit_last;
	wire rx_done = rx_samp && rx_bits_q == CHAR_LAST;
	wire sync_done = rx_done && rx_st_q == RX_SYNC;
	wire id_done = rx_done && rx_st_q == RX_ID;
	wire samp_tick = samp_div_q == OVS_LAST;
	wire hdr_tick = hdr_cyc_q == bit_last;
	wire hdr_late = hdr_on_q && hdr_tick && hdr_bits_q == HDR_TO_BITS - 6'h1;
	wire [26:0] meas_pct = 27'(meas_q) * 27'(PCT_FULL);
	wire [26:0] tol_hi = 27'(to_eighths(brg_q)) * 27'(PCT_FULL + TOL_PCT);
	wire [26:0] tol_lo = 27'(to_eighths(brg_q)) * 27'(PCT_FULL - TOL_PCT);
	wire tol_bad = meas_pct > tol_hi || meas_pct < tol_lo;
	wire sync_bad = rx_sh_q != SYNC_CHAR;
	wire sync_upd = sync_done && !sync_bad && !tol_bad && !sync_dis_q;
	wire [7:0] id_rx_val = par_dis_q ? rx_sh_q : {2'b00, rx_sh_q[5:0]};

	// bus slave: one wait cycle on every access
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				avs_readdata <= rd_word;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mode_q <= MODE_RST;
			par_dis_q <= 1'b0;
			sync_dis_q <= 1'b0;
			brg_q <= BR_RST;
			id_q <= ID_RST;
		end else begin
			if (wr_mode) begin
				mode_q <= mode_new[MODE_LSB +: 4];
				par_dis_q <= mode_new[MODE_PAR_DIS];
				sync_dis_q <= mode_new[MODE_SYNC_DIS];
			end
			if (wr_brg) begin
				brg_q <= brg_new[BR_W-1:0];
			end
			// a received identifier wins over a bus write in the same cycle
			if (id_done) begin
				id_q <= id_rx_val;
			end else if (wr_id && (!is_master || transmitter_ready_flag_q)) begin
				id_q <= avs_writedata[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			lbr_q <= BR_RST;
		end else if (wr_brg && is_slave) begin
			lbr_q <= brg_new[BR_W-1:0];
		end else if (sync_upd) begin
			lbr_q <= {meas_q[2:0], meas_q[BR_W-1:3]};
		end
	end

	// header transmitter; lin_txd high is recessive
	always_ff @(posedge ref_clk) begin
		if (reset || rst_tx || !is_master) begin
			tx_st_q <= TX_IDLE;
			tx_cyc_q <= 20'h0;
			tx_bits_q <= 4'h0;
			tx_sh_q <= 9'h1FF;
			lin_txd <= 1'b1;
			transmitter_ready_flag_q <= 1'b1;
		end else begin
			tx_cyc_q <= tx_tick ? 20'h0 : tx_cyc_q + 20'h1;
			unique case (tx_st_q)
				TX_IDLE: begin
					if (hdr_go) begin
						tx_st_q <= TX_BRK;
						tx_cyc_q <= 20'h0;
						tx_bits_q <= 4'h0;
						lin_txd <= 1'b0;
						transmitter_ready_flag_q <= 1'b0;
					end
				end
				TX_BRK: begin
					if (tx_tick) begin
						tx_bits_q <= tx_bits_q + 4'h1;
						if (tx_bits_q == BRK_TX_BITS - 4'h1) begin
							tx_st_q <= TX_DEL;
							tx_bits_q <= 4'h0;
							lin_txd <= 1'b1;
						end
					end
				end
				TX_DEL: begin
					if (tx_tick) begin
						tx_bits_q <= tx_bits_q + 4'h1;
						if (tx_bits_q == BRK_DEL_BITS - 4'h1) begin
							tx_st_q <= TX_SYNC;
							tx_bits_q <= 4'h0;
							tx_sh_q <= {1'b1, SYNC_CHAR};
							lin_txd <= 1'b0;
						end
					end
				end
				TX_SYNC, TX_ID: begin
					if (tx_char_end) begin
						tx_bits_q <= 4'h0;
						if (tx_st_q == TX_SYNC) begin
							tx_st_q <= TX_ID;
							tx_sh_q <= {1'b1, tx_id_char};
							lin_txd <= 1'b0;
							transmitter_ready_flag_q <= 1'b1;
						end else begin
							tx_st_q <= TX_IDLE;
							lin_txd <= 1'b1;
						end
					end else if (tx_tick) begin
						lin_txd <= tx_sh_q[0];
						tx_sh_q <= {1'b1, tx_sh_q[8:1]};
						tx_bits_q <= tx_bits_q + 4'h1;
					end
				end
			endcase
		end
	end

	// sampling clock enable for the synch measurement
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			samp_div_q <= 4'h0;
			rx_prev_q <= 1'b1;
			low_cnt_q <= 24'h0;
		end else begin
			samp_div_q <= samp_div_q + 4'h1;
			rx_prev_q <= lin_rxd;
			// saturates so a stuck-low bus reports one break only
			if (lin_rxd) begin
				low_cnt_q <= 24'h0;
			end else if (low_cnt_q != brk_thr) begin
				low_cnt_q <= low_cnt_q + 24'h1;
			end
		end
	end

	// header receiver; flag sets are placed after the clear so a set wins
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rx_st_q <= RX_IDLE;
			rx_cyc_q <= 20'h0;
			rx_bits_q <= 4'h0;
			rx_sh_q <= 8'h00;
			hdr_on_q <= 1'b0;
			hdr_cyc_q <= 20'h0;
			hdr_bits_q <= 6'h0;
			meas_q <= BR_RST;
			meas_on_q <= 1'b0;
			edges_q <= 3'h0;
			idrx_q <= 1'b0;
			brk_q <= 1'b0;
			hte_q <= 1'b0;
			ste_q <= 1'b0;
			bad_synch_char_error_q <= 1'b0;
			pare_q <= 1'b0;
		end else begin
			if (sts_clr) begin
				idrx_q <= 1'b0;
				brk_q <= 1'b0;
				hte_q <= 1'b0;
				ste_q <= 1'b0;
				bad_synch_char_error_q <= 1'b0;
				pare_q <= 1'b0;
			end
			rx_cyc_q <= rx_samp ? 20'h0 : rx_cyc_q + 20'h1;
			if (hdr_on_q) begin
				hdr_cyc_q <= hdr_tick ? 20'h0 : hdr_cyc_q + 20'h1;
				hdr_bits_q <= hdr_tick ? hdr_bits_q + 6'h1 : hdr_bits_q;
			end
			if (meas_on_q) begin
				if (rx_fall) begin
					edges_q <= edges_q + 3'h1;
					meas_on_q <= edges_q != SYNC_EDGES - 3'h1;
				end
				// a tick that falls on an edge cycle still counts, else the measurement runs short
				if (samp_tick) begin
					meas_q <= meas_q + 19'h1;
				end
			end
			if (rx_samp && (rx_st_q == RX_SYNC || rx_st_q == RX_ID)) begin
				rx_bits_q <= rx_bits_q + 4'h1;
				if (rx_bits_q != 4'h0 && rx_bits_q != CHAR_LAST) begin
					rx_sh_q <= {lin_rxd, rx_sh_q[7:1]};
				end
			end
			if (rst_rx || !is_slave) begin
				rx_st_q <= RX_IDLE;
				hdr_on_q <= 1'b0;
				meas_on_q <= 1'b0;
			end else if (brk_hit) begin
				rx_st_q <= RX_BRK;
				brk_q <= 1'b1;
				hdr_on_q <= 1'b1;
				hdr_cyc_q <= 20'h0;
				hdr_bits_q <= 6'h0;
				meas_on_q <= 1'b0;
			end else if (hdr_late) begin
				rx_st_q <= RX_IDLE;
				hte_q <= 1'b1;
				hdr_on_q <= 1'b0;
				meas_on_q <= 1'b0;
			end else begin
				unique case (rx_st_q)
					RX_IDLE: begin
						rx_st_q <= RX_IDLE;
					end
					RX_BRK: begin
						if (lin_rxd) begin
							rx_st_q <= RX_SWAIT;
						end
					end
					RX_SWAIT, RX_IWAIT: begin
						if (rx_fall) begin
							// first sample lands mid start bit
							rx_cyc_q <= {1'b0, bit_len[19:1]};
							rx_bits_q <= 4'h0;
							rx_st_q <= rx_st_q == RX_SWAIT ? RX_SYNC : RX_ID;
							if (rx_st_q == RX_SWAIT) begin
								meas_q <= BR_RST;
								meas_on_q <= 1'b1;
								edges_q <= 3'h0;
							end
						end
					end
					RX_SYNC: begin
						if (sync_done) begin
							rx_st_q <= RX_IWAIT;
							meas_on_q <= 1'b0;
							if (sync_bad) begin
								bad_synch_char_error_q <= 1'b1;
							end else if (tol_bad) begin
								ste_q <= 1'b1;
							end
						end
					end
					RX_ID: begin
						if (id_done) begin
							rx_st_q <= RX_IDLE;
							hdr_on_q <= 1'b0;
							idrx_q <= 1'b1;
							if (!par_dis_q && rx_sh_q != lin_pid(rx_sh_q[5:0])) begin
								pare_q <= 1'b1;
							end
						end
					end
				endcase
			end
		end
	end

endmodule

// *** hw/lhs_pkg.sv ***
package lhs_pkg;

	localparam int AW = 8;

	// register byte addresses
	localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
	localparam logic [AW-1:0] ADDR_MODE = 8'h04;
	localparam logic [AW-1:0] ADDR_BRG = 8'h08;
	localparam logic [AW-1:0] ADDR_LBR = 8'h0C;
	localparam logic [AW-1:0] ADDR_ID = 8'h10;
	localparam logic [AW-1:0] ADDR_STAT = 8'h14;

	// control_reg bits
	localparam int CTRL_STATUS_RESET_BIT = 0;
	localparam int CTRL_RSTRX = 1;
	localparam int CTRL_RSTTX = 2;

	// lin_mode_reg fields
	localparam int MODE_LSB = 0;
	localparam int MODE_PAR_DIS = 4;
	localparam int MODE_SYNC_DIS = 5;
	localparam logic [3:0] MODE_MASTER = 4'hA;
	localparam logic [3:0] MODE_SLAVE = 4'hB;

	// baud words: [15:0] divider, [18:16] fraction
	localparam int BR_W = 19;
	localparam int FP_LSB = 16;

	// channel_status_reg bits
	localparam int STAT_TRANSMITTER_READY_FLAG = 0;
	localparam int STAT_IDRX = 1;
	localparam int STAT_BRK = 2;
	localparam int STAT_HTE = 3;
	localparam int STAT_STE = 4;
	localparam int STAT_BAD_SYNCH_CHAR_ERROR = 5;
	localparam int STAT_PARE = 6;

	// reset values
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic [BR_W-1:0] BR_RST = 19'h0_0000;
	localparam logic [7:0] ID_RST = 8'h00;

	// frame figures, in bit times
	localparam logic [7:0] SYNC_CHAR = 8'h55;
	localparam logic [3:0] BRK_TX_BITS = 4'hD;
	localparam logic [3:0] BRK_DEL_BITS = 4'h1;
	localparam logic [3:0] BRK_DET_BITS = 4'hB;
	localparam logic [3:0] CHAR_LAST = 4'h9;
	localparam int HDR_NOM_BITS = 34;
	localparam int HDR_MAX_BITS = (HDR_NOM_BITS * 14 + 9) / 10;
	localparam logic [5:0] HDR_TO_BITS = 6'(HDR_MAX_BITS - int'(BRK_DET_BITS));
	localparam logic [2:0] SYNC_EDGES = 3'h4;
	localparam logic [3:0] OVS_LAST = 4'hF;

	// tolerance on the measured rate, in percent
	localparam logic [7:0] PCT_FULL = 8'h64;
	localparam logic [7:0] TOL_PCT = 8'h0F;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_BRK = 3'b001,
		TX_DEL = 3'b010,
		TX_SYNC = 3'b011,
		TX_ID = 3'b100
	} lhs_tx_e;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_BRK = 3'b001,
		RX_SWAIT = 3'b010,
		RX_SYNC = 3'b011,
		RX_IWAIT = 3'b100,
		RX_ID = 3'b101
	} lhs_rx_e;

endpackage

// *** sim/lhs_hdr_properties.sv ***
module lhs_hdr_properties
	import lhs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [lhs_pkg::AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic lin_rxd,
	input wire logic lin_txd
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [BR_W-1:0] brg_q;
	int lo_q, hi_q, bt;
	logic brk_q, syn_q, req, zaddr;
	assign req = avs_read | avs_write;
	assign bt = 16 * int'(brg_q[15:0]) + 2 * int'(brg_q[18:16]);
	assign zaddr = !(avs_address inside {ADDR_MODE, ADDR_BRG, ADDR_LBR, ADDR_ID, ADDR_STAT});
	// the bit time is tracked from bus writes, since the checker cannot see the registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			brg_q <= '0;
			lo_q <= 0;
			hi_q <= 0;
			brk_q <= 1'b0;
			syn_q <= 1'b0;
		end else begin
			if (avs_write && !avs_waitrequest && avs_address == ADDR_BRG)
				brg_q <= avs_writedata[BR_W-1:0];
			lo_q <= lin_txd ? 0 : lo_q + 1;
			hi_q <= lin_txd ? hi_q + 1 : 0;
			if (lin_txd && lo_q > 9 * bt)
				brk_q <= 1'b1;
			else if (!lin_txd)
				brk_q <= 1'b0;
			if (!lin_txd && brk_q)
				syn_q <= 1'b1;
			else if (lin_txd)
				syn_q <= 1'b0;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	wait_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait state");
	wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	wait_idle_a: assert property (!req && avs_waitrequest |=> avs_waitrequest)
		else $error("answer without a request");
	zero_read_a: assert property (avs_read && avs_waitrequest && zaddr |=> avs_readdata == 32'h0)
		else $error("write-only or unmapped place read nonzero");
	rst_idle_a: assert property ($fell(reset) |-> lin_txd && avs_waitrequest && avs_readdata == 32'h0)
		else $error("outputs not idle after reset");
	break_max_a: assert property (!lin_txd |-> lo_q < 13 * bt)
		else $error("dominant run longer than a break");
	break_len_a: assert property ($rose(lin_txd) && lo_q > 9 * bt |-> lo_q == 13 * bt)
		else $error("break length wrong");
	delim_len_a: assert property ($fell(lin_txd) && brk_q |-> hi_q == bt)
		else $error("break delimiter length wrong");
	sync_start_a: assert property ($rose(lin_txd) && syn_q |-> lo_q == bt)
		else $error("synch start bit length wrong");
	cover property (avs_read && !avs_waitrequest);
	cover property (avs_write && !avs_waitrequest);
	cover property ($fell(lin_txd) && brk_q);
endmodule

// *** sim/lhs_lin_node.sv ***
module lhs_lin_node (
	input wire logic ref_clk,
	output logic txd
);
	timeunit 1ns;
	timeprecision 1ps;
	// the bus is pulled recessive, so a quiet node drives 1
	initial txd = 1'b1;
	task automatic hold(input int t, input logic v);
		txd <= v;
		repeat (t) @(posedge ref_clk);
	endtask
	task automatic send_char(input int t, input logic [7:0] c);
		hold(t, 1'b0);
		for (int i = 0; i < 8; i++)
			hold(t, c[i]);
		hold(t, 1'b1);
	endtask
	// cut stops after the synch field to provoke a header time-out
	task automatic send_hdr(input int t, input logic [7:0] syn, input logic [7:0] id, input bit cut);
		hold(13 * t, 1'b0);
		hold(t, 1'b1);
		send_char(t, syn);
		if (!cut)
			send_char(t, id);
	endtask
endmodule

// *** sim/lhs_tb.sv ***
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lhs_pkg::*;
	localparam int BT = 16 * 4;
	logic ref_clk, reset, avs_read, avs_write, avs_waitrequest, lin_rxd, lin_txd, node_txd;
	logic [AW-1:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [7:0] idv, got;
	int bad_count, num_checks, cyc, t;
	always #2.5 ref_clk = ~ref_clk;
	assign lin_rxd = lin_txd & node_txd;
	lhs_lin_header_sync_engine dut (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lin_rxd(lin_rxd), .lin_txd(lin_txd));
	lhs_lin_node node (.ref_clk(ref_clk), .txd(node_txd));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask
	function automatic logic [31:0] rate_word(input int k);
		return {13'h0, 3'(k), 16'(k >> 3)};
	endfunction
	// the sampling clock free-runs, so one tick either way is accepted
	task automatic check_rate(input logic [31:0] g, input int k);
		logic [31:0] e;
		e = rate_word(k);
		if (g === rate_word(k - 1) || g === rate_word(k + 1))
			e = g;
		check(g, e);
	endtask
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus_rd(a, rd);
		check(rd & m, e);
	endtask
	// protected identifier: two parity bits above the six identifier bits
	function automatic logic [7:0] pid_of(input logic [5:0] i);
		return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
	endfunction
	task automatic wait_txd(input logic v, input int lim);
		int n;
		n = 0;
		while (lin_txd !== v && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		check(32'(n < lim), 32'h1);
	endtask
	task automatic get_byte(output logic [7:0] c);
		wait_txd(1'b1, 16 * BT);
		wait_txd(1'b0, 2 * BT);
		repeat (BT / 2) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BT) @(posedge ref_clk);
			c[i] = lin_txd;
		end
	endtask
	task automatic setup_slave(input logic [31:0] mode);
		bus_wr(ADDR_MODE, mode);
		bus_wr(ADDR_CTRL, 32'h7);
		bus_wr(ADDR_BRG, 32'h4);
		rd_chk(ADDR_LBR, '1, 32'h4);
	endtask
	initial begin
		ref_clk = 1'b0;
		reset = 1'b1;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		bad_count = 0;
		num_checks = 0;
		cyc = 0;
		rd = $urandom(32'h64f4);
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		rd_chk(ADDR_MODE, '1, 32'h0);
		rd_chk(ADDR_STAT, '1, 32'h1);
		rd_chk(8'h18, '1, 32'h0);
		bus_wr(ADDR_LBR, 32'h5);
		rd_chk(ADDR_LBR, '1, 32'h0);
		$display("test reset done");
		bus_wr(ADDR_MODE, 32'h1A);
		rd_chk(ADDR_MODE, '1, 32'h1A);
		bus_wr(ADDR_BRG, 32'h4);
		idv = 8'($urandom);
		bus_wr(ADDR_ID, {24'h0, idv});
		rd_chk(ADDR_STAT, 32'h1, 32'h0);
		bus_wr(ADDR_ID, 32'h0);
		get_byte(got);
		check({24'h0, got}, 32'h55);
		get_byte(got);
		check({24'h0, got}, {24'h0, idv});
		rd_chk(ADDR_STAT, 32'h1, 32'h1);
		rd_chk(ADDR_ID, 32'hFF, {24'h0, idv});
		repeat (2 * BT) @(posedge ref_clk);
		$display("test master done");
		t = 62 + 2 * int'($urandom % 4);
		idv = 8'($urandom);
		setup_slave(32'h1B);
		node.send_char(BT, 8'h00);
		rd_chk(ADDR_STAT, 32'h3E, 32'h0);
		node.send_hdr(t, 8'h55, idv, 1'b0);
		repeat (BT) @(posedge ref_clk);
		rd_chk(ADDR_STAT, 32'h3E, 32'h6);
		rd_chk(ADDR_ID, 32'hFF, {24'h0, idv});
		bus_rd(ADDR_LBR, rd);
		rd_chk(ADDR_LBR, '1, rd);
		check_rate(rd, t / 2);
		bus_wr(ADDR_CTRL, 32'h1);
		rd_chk(ADDR_STAT, 32'h3E, 32'h0);
		$display("test slave done");
		setup_slave(32'h1B);
		node.send_hdr(BT, 8'h55 ^ (8'h1 << ($urandom % 8)), idv, 1'b0);
		repeat (BT) @(posedge ref_clk);
		rd_chk(ADDR_STAT, 32'h20, 32'h20);
		rd_chk(ADDR_LBR, '1, 32'h4);
		bus_wr(ADDR_CTRL, 32'h1);
		rd_chk(ADDR_STAT, 32'h30, 32'h0);
		// initial rate moved while in master mode, so sampling stays at the true rate
		bus_wr(ADDR_MODE, 32'h1A);
		bus_wr(ADDR_BRG, 32'h5);
		bus_wr(ADDR_MODE, 32'h1B);
		bus_wr(ADDR_CTRL, 32'h7);
		node.send_hdr(BT, 8'h55, idv, 1'b0);
		rd_chk(ADDR_STAT, 32'h30, 32'h10);
		rd_chk(ADDR_LBR, '1, 32'h4);
		setup_slave(32'h3B);
		node.send_hdr(68, 8'h55, idv, 1'b0);
		rd_chk(ADDR_LBR, '1, 32'h4);
		setup_slave(32'h0B);
		node.send_hdr(BT, 8'h55, pid_of(idv[5:0]) ^ 8'h40, 1'b0);
		rd_chk(ADDR_STAT, 32'h42, 32'h42);
		rd_chk(ADDR_ID, 32'hFF, {26'h0, idv[5:0]});
		$display("test synch errors done");
		setup_slave(32'h1B);
		node.send_hdr(BT, 8'h55, idv, 1'b1);
		repeat (20 * BT) @(posedge ref_clk);
		rd_chk(ADDR_STAT, 32'h8, 32'h0);
		repeat (6 * BT) @(posedge ref_clk);
		rd_chk(ADDR_STAT, 32'h8, 32'h8);
		bus_wr(ADDR_CTRL, 32'h1);
		rd_chk(ADDR_STAT, 32'h3E, 32'h0);
		$display("test timeout done");
		end_sim();
	end
endmodule
bind lhs_lin_header_sync_engine lhs_hdr_properties chk (.ref_clk(ref_clk), .reset(reset),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.lin_rxd(lin_rxd), .lin_txd(lin_txd));
